// ---- bio_params.svh ----
// Constants for the bidirectional port block: offsets, field values, reset values
`ifndef BIO_PARAMS_SVH
`define BIO_PARAMS_SVH

// Number of ports, A to F
`define BIO_NUM_PORTS 6
// Index of the last port, which has one bit only
`define BIO_LAST_PORT 5
// Byte offset between the register groups of two ports
`define BIO_PORT_STRIDE 8'h04
// Register within a port group, taken from address bits 1:0
`define BIO_SUB_DATA 2'h0
`define BIO_SUB_DIR 2'h1
`define BIO_SUB_PULL 2'h2
`define BIO_SUB_WAKE 2'h3
// Port A wake-up enable register address
`define BIO_OFS_WAKE 8'h03
// Highest mapped address
`define BIO_OFS_LAST 8'h17
// Implemented-bit masks
`define BIO_MASK_FULL 8'hFF
`define BIO_MASK_ONE 8'h01
// Reset values
`define BIO_DATA_RST 8'hFF
`define BIO_DIR_RST 8'hFF
`define BIO_PULL_RST 8'h00
`define BIO_WAKE_RST 8'h00
// Answer to an unmapped read
`define BIO_UNMAPPED 8'h00

`endif

// ---- bio_pkg.sv ----
// Types shared by the bidirectional port block
package bio_pkg;

    // State of one port's register group
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] pull;
        logic [7:0] pull_on;
        logic [7:0] oe_n;
    } bio_bank_t;

    // State of the port A wake-up detector
    typedef struct packed {
        logic [7:0] en;
        logic [7:0] prev;
        logic req;
    } bio_wake_t;

    // State of the top-level read port
    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } bio_top_t;

endpackage

// ---- bio_port_bank.sv ----
// One port: data latch, direction and pull-high registers with pin drive
`timescale 1ns/1ps
`include "bio_params.svh"

module bio_port_bank #(
    parameter logic [7:0] IMPL_MASK = `BIO_MASK_FULL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register writes
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic wr_pull,
    input wire logic [7:0] wdata,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pin_pull,
    // Register views
    output logic [7:0] dir,
    output logic [7:0] pull,
    output logic [7:0] read_val
);

    bio_pkg::bio_bank_t st;
    bio_pkg::bio_bank_t next_st;

    // Register updates; unimplemented bits stay at zero
    always_comb
    begin
        next_st = st;
        if (wr_data)
        begin
            next_st.data = wdata & IMPL_MASK;
        end
        if (wr_dir)
        begin
            next_st.dir = wdata & IMPL_MASK;
        end
        if (wr_pull)
        begin
            next_st.pull = wdata & IMPL_MASK;
        end
        next_st.pull_on = next_st.pull & next_st.dir;
        next_st.oe_n = next_st.dir | ~IMPL_MASK;
    end

    // State register; latch starts high so a new output drives high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '{data: `BIO_DATA_RST & IMPL_MASK,
                    dir: `BIO_DIR_RST & IMPL_MASK,
                    pull: `BIO_PULL_RST,
                    pull_on: `BIO_PULL_RST,
                    oe_n: `BIO_MASK_FULL};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs
    assign pin_out = st.data;
    assign pin_oe_n = st.oe_n;
    assign pin_pull = st.pull_on;
    assign dir = st.dir;
    assign pull = st.pull;
    // Inputs read the pin live, outputs read the latch
    assign read_val = ((st.dir & pin_in) | (~st.dir & st.data)) & IMPL_MASK;

endmodule

// ---- bio_wake_detect.sv ----
// Port A wake-up: per-pin enable and falling-edge detection
`timescale 1ns/1ps
`include "bio_params.svh"

module bio_wake_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Enable register write
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    // Port A pins and direction
    input wire logic [7:0] pin_in,
    input wire logic [7:0] dir,
    // Power mode
    input wire logic sleep_mode,
    // Results
    output logic [7:0] wake_en,
    output logic wake_req
);

    bio_pkg::bio_wake_t st;
    bio_pkg::bio_wake_t next_st;

    // Enable register, last pin levels and the combined request
    always_comb
    begin
        next_st = st;
        if (wr_en)
        begin
            next_st.en = wdata;
        end
        next_st.prev = pin_in;
        // Only enabled input pins that were high and are now low count
        next_st.req = sleep_mode && ((st.prev & ~pin_in & st.en & dir) != 8'h00);
    end

    // State register; last levels reset low so release shows no false edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '{en: `BIO_WAKE_RST, prev: 8'h00, req: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs
    assign wake_en = st.en;
    assign wake_req = st.req;

endmodule

// ---- bio_ports.sv ----
// Six bidirectional ports with a data-memory register port and port A wake-up
`timescale 1ns/1ps
`include "bio_params.svh"

// What this block does
// - Input reads sample pin levels directly in the read cycle, no input latch
// - Output data latch holds until software writes the port data again
// - Direction 1 makes the pin an input, 0 a CMOS output from latch
// - Reading an input pin returns the present pin level
// - Reading an output pin returns the latch, not the pin level
// - Pull-high connects on input pins whose pull enable is 1
// - Pull-high enables are read/write and reset to zero
// - In sleep or idle, a falling enabled port A input pin wakes the device
// - Each port A pin has a wake enable bit, reset to zero
// - Reset sets all data and direction registers to ones
// - A pin turned output before any data write drives high
// - Port F implements bit 0 only; bits 7 to 1 read zero

module bio_ports (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Data memory register port
    input wire logic [7:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_rvalid,
    // Pins, one byte per port, port A in bits 7:0
    input wire logic [47:0] pin_in,
    output logic [47:0] pin_out,
    output logic [47:0] pin_oe_n,
    output logic [47:0] pin_pull,
    // Power mode
    input wire logic sleep_mode,
    output logic wake_req
);

    bio_pkg::bio_top_t st;
    bio_pkg::bio_top_t next_st;
    logic [7:0] read_val [`BIO_NUM_PORTS];
    logic [7:0] dir_val [`BIO_NUM_PORTS];
    logic [7:0] pull_val [`BIO_NUM_PORTS];
    logic [7:0] wake_en;
    logic addr_mapped;
    logic [2:0] port_idx;
    logic [1:0] sub_sel;

    // Address split: port group in bits 4:2, register in bits 1:0
    assign port_idx = mem_addr[4:2];
    assign sub_sel = mem_addr[1:0];
    assign addr_mapped = (mem_addr <= `BIO_OFS_LAST);

    // One register group per port; the last port has bit 0 only
    genvar gi;
    generate
        for (gi = 0; gi < `BIO_NUM_PORTS; gi++)
        begin : g_port
            localparam logic [7:0] MASK = (gi == `BIO_LAST_PORT) ? `BIO_MASK_ONE : `BIO_MASK_FULL;
            logic hit;
            assign hit = mem_wr && addr_mapped && (port_idx == 3'(gi));
            bio_port_bank #(
                .IMPL_MASK(MASK)
            ) u_bank (
                .clk(clk),
                .rstn(rstn),
                .wr_data(hit && (sub_sel == `BIO_SUB_DATA)),
                .wr_dir(hit && (sub_sel == `BIO_SUB_DIR)),
                .wr_pull(hit && (sub_sel == `BIO_SUB_PULL)),
                .wdata(mem_wdata),
                .pin_in(pin_in[gi*8 +: 8]),
                .pin_out(pin_out[gi*8 +: 8]),
                .pin_oe_n(pin_oe_n[gi*8 +: 8]),
                .pin_pull(pin_pull[gi*8 +: 8]),
                .dir(dir_val[gi]),
                .pull(pull_val[gi]),
                .read_val(read_val[gi])
            );
        end
    endgenerate

    // Port A wake-up detector
    bio_wake_detect u_wake (
        .clk(clk),
        .rstn(rstn),
        .wr_en(mem_wr && (mem_addr == `BIO_OFS_WAKE)),
        .wdata(mem_wdata),
        .pin_in(pin_in[7:0]),
        .dir(dir_val[0]),
        .sleep_mode(sleep_mode),
        .wake_en(wake_en),
        .wake_req(wake_req)
    );

    // Read multiplexer; pins are sampled in the read cycle itself
    always_comb
    begin
        next_st.rvalid = mem_rd;
        next_st.rdata = st.rdata;
        if (mem_rd)
        begin
            next_st.rdata = `BIO_UNMAPPED;
            if (addr_mapped)
            begin
                case (sub_sel)
                    `BIO_SUB_DATA: next_st.rdata = read_val[port_idx];
                    `BIO_SUB_DIR: next_st.rdata = dir_val[port_idx];
                    `BIO_SUB_PULL: next_st.rdata = pull_val[port_idx];
                    default: next_st.rdata = (port_idx == 3'd0) ? wake_en : `BIO_UNMAPPED;
                endcase
            end
        end
    end

    // Read port registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '{rdata: `BIO_UNMAPPED, rvalid: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign mem_rdata = st.rdata;
    assign mem_rvalid = st.rvalid;

endmodule

// ---- bio_ports_asserts.sv ----
// Checker for the bidirectional port block
`timescale 1ns/1ps
module bio_ports_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    // Pins and power mode
    input wire logic [47:0] pin_in,
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe_n,
    input wire logic [47:0] pin_pull,
    input wire logic sleep_mode,
    input wire logic wake_req
);
    logic [7:0] prev_a;
    logic [7:0] fall_a;
    logic [7:0] rd_exp;
    logic wake_cause;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Port A levels one cycle back
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prev_a <= 8'h00;
        else
            prev_a <= pin_in[7:0];
    end
    // Falling input pins and the expected port A read value
    assign fall_a = prev_a & ~pin_in[7:0] & pin_oe_n[7:0];
    assign wake_cause = sleep_mode && (fall_a != 8'h00);
    assign rd_exp = (pin_in[7:0] & pin_oe_n[7:0]) | (pin_out[7:0] & ~pin_oe_n[7:0]);
    sequence s_read_a;
        mem_rd && mem_addr == 8'h00;
    endsequence
    sequence s_quiet;
        (!mem_wr) [*2];
    endsequence
    a_read_valid: assert property (mem_rvalid == $past(mem_rd)) else $error("rvalid timing");
    a_read_pins: assert property (s_read_a |=> mem_rdata == $past(rd_exp)) else $error("port read");
    a_rdata_hold: assert property (!mem_rvalid |-> $stable(mem_rdata)) else $error("rdata moved");
    a_latch_hold: assert property (s_quiet |=> $stable(pin_out)) else $error("latch moved");
    a_pull_input: assert property ((pin_pull & ~pin_oe_n) == 48'h0) else $error("pull on output");
    a_port_f_top: assert property (pin_out[47:41] == 7'h00 && pin_pull[47:41] == 7'h00) else $error("port top");
    a_wake_cause: assert property (wake_req |-> $past(wake_cause)) else $error("wake cause");
    a_wake_awake: assert property (!sleep_mode |=> !wake_req) else $error("wake awake");
endmodule
bind bio_ports bio_ports_chk chk_u (
    .clk(clk),
    .rstn(rstn),
    .mem_addr(mem_addr),
    .mem_wr(mem_wr),
    .mem_rd(mem_rd),
    .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_pull(pin_pull),
    .sleep_mode(sleep_mode),
    .wake_req(wake_req)
);

// ---- bio_pin_model.sv ----
// Far side model: drivers and loads on the port pins
`timescale 1ns/1ps
module bio_pin_model (
    // Clock
    input wire logic clk,
    // Block pin side
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe_n,
    input wire logic [47:0] pin_pull,
    output logic [47:0] pin_in,
    // External drivers
    input wire logic [47:0] ext_en,
    input wire logic [47:0] ext_val
);
    logic [47:0] last = 48'h0;
    // Floating pins drift away from their last level
    always @(posedge clk)
        last <= pin_in;
    // Block drive wins, then external drive, then pull-high
    assign pin_in = (~pin_oe_n & pin_out)
        | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & pin_pull)
        | (pin_oe_n & ~ext_en & ~pin_pull & ~last);
endmodule

// ---- testbench.sv ----
// Testbench for the bidirectional port block
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rstn = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0, sleep_mode = 1'b0;
    logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, mem_rdata, v, m;
    logic mem_rvalid, wake_req;
    logic [47:0] pin_in, pin_out, pin_oe_n, pin_pull;
    logic [47:0] ext_en = {48{1'b1}}, ext_val = 48'h5b5a_96a5_c33c;
    int n_mismatch = 0, n_tests = 0, i;
    always #10 clk = ~clk;
    bio_ports dut_u (
        .clk(clk),
        .rstn(rstn),
        .mem_addr(mem_addr),
        .mem_wr(mem_wr),
        .mem_rd(mem_rd),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n),
        .pin_pull(pin_pull),
        .sleep_mode(sleep_mode),
        .wake_req(wake_req)
    );
    bio_pin_model pins_u (
        .clk(clk),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n),
        .pin_pull(pin_pull),
        .pin_in(pin_in),
        .ext_en(ext_en),
        .ext_val(ext_val)
    );
    // Compare one value
    task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Verdict and end of run
    task stop_test;
        if (n_mismatch == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One register write, then let the pins settle
    task wr(input logic [7:0] a, input logic [7:0] d);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'b1;
        @(negedge clk);
        mem_wr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // One register read with a bounded wait for valid
    task rd(input logic [7:0] a, input logic [7:0] e, output logic [7:0] g);
        int k;
        mem_addr = a;
        mem_rd = 1'b1;
        @(negedge clk);
        mem_rd = 1'b0;
        for (k = 0; k < 4 && mem_rvalid !== 1'b1; k++)
            @(negedge clk);
        if (k == 4)
        begin
            n_mismatch++;
            stop_test;
        end
        g = mem_rdata;
        chk("rdata", {40'h0, e}, {40'h0, g});
        // Let an edge pass so a following read starts in a new time step
        @(negedge clk);
    endtask
    // Watch four cycles for a wake request
    task wk(input logic e);
        logic s;
        s = 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            s = s | wake_req;
        end
        chk("wake", {47'h0, e}, {47'h0, s});
    endtask
    // Main sequence
    initial
    begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        chk("oe_n", {48{1'b1}}, pin_oe_n);
        chk("out", 48'h01ff_ffff_ffff, pin_out);
        for (i = 0; i < 6; i++)
        begin
            m = (i == 5) ? 8'h01 : 8'hff;
            rd(8'(4 * i), ext_val[8 * i +: 8] & m, v);
            rd(8'(4 * i + 1), m, v);
            rd(8'(4 * i + 2), 8'h00, v);
            wr(8'(4 * i + 2), 8'hff);
            rd(8'(4 * i + 2), m, v);
        end
        rd(8'h03, 8'h00, v);
        chk("pull", 48'h01ff_ffff_ffff, pin_pull);
        ext_en[15:8] = 8'h00;
        rd(8'h04, 8'hff, v);
        ext_val[7:0] = 8'h00;
        wr(8'h01, 8'hf0);
        chk("pin", 48'h0000_0000_000f, {40'h0, pin_in[7:0]});
        chk("oe_n", 48'h0000_0000_00f0, {40'h0, pin_oe_n[7:0]});
        rd(8'h00, 8'h0f, v);
        chk("pull", 48'h0000_0000_00f0, {40'h0, pin_pull[7:0]});
        wr(8'h00, v & 8'hfe);
        wr(8'h01, 8'h00);
        chk("out", 48'h0000_0000_000e, {40'h0, pin_out[7:0]});
        rd(8'h00, 8'h0e, v);
        wr(8'h01, 8'hff);
        ext_val[7:0] = 8'hff;
        wr(8'h03, 8'h04);
        rd(8'h03, 8'h04, v);
        sleep_mode = 1'b1;
        ext_val[1] = 1'b0;
        wk(1'b0);
        ext_val[2] = 1'b0;
        wk(1'b1);
        ext_val[2] = 1'b1;
        sleep_mode = 1'b0;
        @(negedge clk);
        ext_val[2] = 1'b0;
        wk(1'b0);
        rd(8'h20, 8'h00, v);
        stop_test;
    end
endmodule
